//--- hw/stml_consts.svh
/*
 Offsets, field positions, reset values and codes of the timer mode logic.
 Assumes inclusion by bare name from any file that needs them.
*/
`ifndef STML_CONSTS_SVH
`define STML_CONSTS_SVH

// Register offsets (word index on the plain register port)
`define STML_ADDR_CTRL0    3'h0
`define STML_ADDR_CTRL1    3'h1
`define STML_ADDR_COUNT    3'h2
`define STML_ADDR_CMPA     3'h3
`define STML_ADDR_FLAGS    3'h4

// Control zero fields
`define STML_C0_PVAL_LO    0
`define STML_C0_PVAL_HI    2
`define STML_C0_EN         3
`define STML_C0_TRIG_FALL  4

// Control one fields
`define STML_C1_CCLR       0
`define STML_C1_DPX        1
`define STML_C1_POL        2
`define STML_C1_OC         3
`define STML_C1_IO_LO      4
`define STML_C1_IO_HI      5
`define STML_C1_MODE_LO    6
`define STML_C1_MODE_HI    7

// Flag fields
`define STML_FL_A          0
`define STML_FL_P          1

// Widths and values
`define STML_DW            16
`define STML_CNT_ZERO      10'h000
`define STML_P_ZERO        3'h0
`define STML_LOW7_ZERO     7'h00
`define STML_CNT_ONE       10'h001
`define STML_FULL_PERIOD   11'h400
`define STML_RD_ZERO       16'h0000
`define STML_C1_RESET      8'h00

// Pin action codes
`define STML_IO_00         2'b00
`define STML_IO_01         2'b01
`define STML_IO_10         2'b10
`define STML_IO_11         2'b11

`endif

//--- hw/stml_pkg.sv
/*
 Types of the timer mode logic.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package stml_pkg;

  typedef enum logic [1:0] {
    STML_MODE_CMP = 2'b00,
    STML_MODE_CAP = 2'b01,
    STML_MODE_PWM = 2'b10,
    STML_MODE_TMR = 2'b11
  } stml_mode_t;

endpackage

//--- hw/stml_timer.sv
/*
 Ten-bit standard timer with compare, timer, PWM, single pulse and capture modes.
 Assumes count_tick is a one-cycle pulse per selected timer clock and all pins
 are synchronous to core_clk.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "stml_consts.svh"

module stml_timer
  import stml_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        count_tick,
  input  wire logic        external_trigger_pin,
  input  wire logic        timer_pin_in,
  output logic             timer_pin_out,
  output logic             timer_pin_oe,
  output logic             match_a_flag,
  output logic             match_p_flag
);

  logic             counter_enable_q, counter_enable_d;
  logic [2:0]       compare_p_value_q, compare_p_value_d;
  logic             trig_fall_q, trig_fall_d;
  logic [7:0]       ctrl1_q, ctrl1_d;
  logic [9:0]       cnt_q, cnt_d;
  logic [9:0]       compare_a_value_q, compare_a_value_d;
  logic             flag_a_q, flag_a_d;
  logic             flag_p_q, flag_p_d;
  logic             lvl_q, lvl_d;
  logic             pin_out_q, pin_out_d;
  logic             pin_oe_q, pin_oe_d;
  logic             trig_prev_q, cap_prev_q;
  logic [15:0]      rdata_q, rdata_d;

  stml_mode_t       mode;
  logic [1:0]       pin_action;
  logic             output_initial_level, output_invert;
  logic             period_duty_swap, clear_source_select;
  logic [9:0]       cnt_next;
  logic             tick, p_hit, a_hit, single, trig_edge, cap_fire;
  logic             en_rise, cnt_clear, set_a, set_p;
  logic [10:0]      p_span, duty_val;
  logic             pwm_on, wr_c0, wr_c1, wr_a, wr_fl;

  // Decoded control fields
  always_comb begin
    mode                 = stml_mode_t'(ctrl1_q[`STML_C1_MODE_HI:`STML_C1_MODE_LO]);
    pin_action           = ctrl1_q[`STML_C1_IO_HI:`STML_C1_IO_LO];
    output_initial_level = ctrl1_q[`STML_C1_OC];
    output_invert        = ctrl1_q[`STML_C1_POL];
    period_duty_swap     = ctrl1_q[`STML_C1_DPX];
    clear_source_select  = ctrl1_q[`STML_C1_CCLR];
    wr_c0 = reg_wr && (reg_addr == `STML_ADDR_CTRL0);
    wr_c1 = reg_wr && (reg_addr == `STML_ADDR_CTRL1);
    wr_a  = reg_wr && (reg_addr == `STML_ADDR_CMPA);
    wr_fl = reg_wr && (reg_addr == `STML_ADDR_FLAGS);
  end

  // Match and edge detection
  always_comb begin
    tick     = count_tick && counter_enable_q;
    cnt_next = cnt_q + `STML_CNT_ONE;
    // Top three bits against P; P zero hits on wrap
    p_hit    = tick && (cnt_next[6:0] == `STML_LOW7_ZERO)
               && (cnt_next[9:7] == compare_p_value_q);
    a_hit    = tick && (cnt_next == compare_a_value_q);
    single   = (mode == STML_MODE_PWM) && (pin_action == `STML_IO_11);
    trig_edge = trig_fall_q ? (trig_prev_q && !external_trigger_pin)
                            : (!trig_prev_q && external_trigger_pin);
    case (pin_action)
      `STML_IO_00: cap_fire = !cap_prev_q && timer_pin_in;
      `STML_IO_01: cap_fire = cap_prev_q && !timer_pin_in;
      `STML_IO_10: cap_fire = cap_prev_q != timer_pin_in;
      default:     cap_fire = 1'b0;
    endcase
    cap_fire = cap_fire && counter_enable_q && (mode == STML_MODE_CAP);
    p_span   = (compare_p_value_q == `STML_P_ZERO) ? `STML_FULL_PERIOD
               : {1'b0, compare_p_value_q, `STML_LOW7_ZERO};
  end

  // Enable, counter, flags and capture
  always_comb begin
    counter_enable_d  = counter_enable_q;
    compare_p_value_d = compare_p_value_q;
    trig_fall_d       = trig_fall_q;
    ctrl1_d           = ctrl1_q;
    compare_a_value_d = compare_a_value_q;
    if (wr_c0) begin
      counter_enable_d  = reg_wdata[`STML_C0_EN];
      compare_p_value_d = reg_wdata[`STML_C0_PVAL_HI:`STML_C0_PVAL_LO];
      trig_fall_d       = reg_wdata[`STML_C0_TRIG_FALL];
    end
    if (wr_c1) begin
      ctrl1_d = reg_wdata[7:0];
    end
    if (single && trig_edge && !counter_enable_q) begin
      counter_enable_d = 1'b1;
    end
    if (single && a_hit) begin
      counter_enable_d = 1'b0;
    end
    en_rise = counter_enable_d && !counter_enable_q;
    case (mode)
      STML_MODE_CMP, STML_MODE_TMR: begin
        cnt_clear = clear_source_select ? a_hit : p_hit;
        set_a     = a_hit;
        set_p     = p_hit && !clear_source_select;
      end
      STML_MODE_PWM: begin
        cnt_clear = single ? 1'b0
                    : (period_duty_swap ? a_hit : p_hit);
        set_a     = a_hit;
        set_p     = p_hit && !single;
      end
      STML_MODE_CAP: begin
        cnt_clear = p_hit;
        set_a     = cap_fire;
        set_p     = p_hit;
      end
      default: begin
        cnt_clear = 1'b0;
        set_a     = 1'b0;
        set_p     = 1'b0;
      end
    endcase
    if (en_rise) begin
      cnt_d = `STML_CNT_ZERO;
    end else if (tick) begin
      cnt_d = cnt_clear ? `STML_CNT_ZERO : cnt_next;
    end else begin
      cnt_d = cnt_q;
    end
    if (wr_a) begin
      compare_a_value_d = reg_wdata[9:0];
    end
    if (cap_fire) begin
      compare_a_value_d = cnt_q;
    end
    // Set beats a clear in the same cycle
    flag_a_d = (flag_a_q && !(wr_fl && reg_wdata[`STML_FL_A])) || set_a;
    flag_p_d = (flag_p_q && !(wr_fl && reg_wdata[`STML_FL_P])) || set_p;
  end

  // Pin drive
  always_comb begin
    lvl_d = lvl_q;
    if (en_rise) begin
      lvl_d = output_initial_level;
    end else if ((mode == STML_MODE_CMP) && a_hit) begin
      case (pin_action)
        `STML_IO_01: lvl_d = 1'b0;
        `STML_IO_10: lvl_d = 1'b1;
        `STML_IO_11: lvl_d = !lvl_q;
        default:     lvl_d = lvl_q;
      endcase
    end
    duty_val = period_duty_swap ? p_span
               : {1'b0, compare_a_value_d};
    pwm_on   = {1'b0, cnt_d} < duty_val;
    pin_out_d = pin_out_q;
    pin_oe_d  = 1'b0;
    case (mode)
      STML_MODE_CMP: begin
        pin_out_d = lvl_d ^ output_invert;
        pin_oe_d  = 1'b1;
      end
      STML_MODE_PWM: begin
        pin_oe_d = 1'b1;
        case (pin_action)
          `STML_IO_00: pin_out_d = !output_initial_level ^ output_invert;
          `STML_IO_01: pin_out_d = output_initial_level ^ output_invert;
          `STML_IO_10: pin_out_d = (pwm_on ? output_initial_level
                                           : !output_initial_level) ^ output_invert;
          default:     pin_out_d = (counter_enable_d ? output_initial_level
                                   : !output_initial_level) ^ output_invert;
        endcase
      end
      default: begin
        pin_out_d = pin_out_q;
        pin_oe_d  = 1'b0;
      end
    endcase
  end

  // Read port
  always_comb begin
    rdata_d = `STML_RD_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        `STML_ADDR_CTRL0: begin
          rdata_d[`STML_C0_PVAL_HI:`STML_C0_PVAL_LO] = compare_p_value_q;
          rdata_d[`STML_C0_EN]                       = counter_enable_q;
          rdata_d[`STML_C0_TRIG_FALL]                = trig_fall_q;
        end
        `STML_ADDR_CTRL1: rdata_d[7:0] = ctrl1_q;
        `STML_ADDR_COUNT: rdata_d[9:0] = cnt_q;
        `STML_ADDR_CMPA:  rdata_d[9:0] = compare_a_value_q;
        `STML_ADDR_FLAGS: begin
          rdata_d[`STML_FL_A] = flag_a_q;
          rdata_d[`STML_FL_P] = flag_p_q;
        end
        default: rdata_d = `STML_RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      counter_enable_q  <= 1'b0;
      compare_p_value_q <= `STML_P_ZERO;
      trig_fall_q       <= 1'b0;
      ctrl1_q           <= `STML_C1_RESET;
      cnt_q             <= `STML_CNT_ZERO;
      compare_a_value_q <= `STML_CNT_ZERO;
      flag_a_q          <= 1'b0;
      flag_p_q          <= 1'b0;
      lvl_q             <= 1'b0;
      pin_out_q         <= 1'b0;
      pin_oe_q          <= 1'b0;
      trig_prev_q       <= 1'b0;
      cap_prev_q        <= 1'b0;
      rdata_q           <= `STML_RD_ZERO;
    end else begin
      counter_enable_q  <= counter_enable_d;
      compare_p_value_q <= compare_p_value_d;
      trig_fall_q       <= trig_fall_d;
      ctrl1_q           <= ctrl1_d;
      cnt_q             <= cnt_d;
      compare_a_value_q <= compare_a_value_d;
      flag_a_q          <= flag_a_d;
      flag_p_q          <= flag_p_d;
      lvl_q             <= lvl_d;
      pin_out_q         <= pin_out_d;
      pin_oe_q          <= pin_oe_d;
      trig_prev_q       <= external_trigger_pin;
      cap_prev_q        <= timer_pin_in;
      rdata_q           <= rdata_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign timer_pin_out = pin_out_q;
  assign timer_pin_oe  = pin_oe_q;
  assign match_a_flag  = flag_a_q;
  assign match_p_flag  = flag_p_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_en_rise_clear: assert property (
    $rose(counter_enable_q) |-> (cnt_q == `STML_CNT_ZERO))
    else $error("counter not zero after enable rise");

  chk_en_low_hold: assert property (
    (!counter_enable_q && !en_rise) |=> $stable(cnt_q))
    else $error("counter moved while disabled");

  chk_pin_initial: assert property (
    (mode == STML_MODE_CMP && !wr_c1 && en_rise)
    |=> (timer_pin_out == ($past(output_initial_level) ^ $past(output_invert))))
    else $error("pin not at initial level after enable rise");

  chk_p_match_clear: assert property (
    (mode == STML_MODE_CMP && !clear_source_select && p_hit && !en_rise)
    |=> (cnt_q == `STML_CNT_ZERO) && match_p_flag)
    else $error("P match did not clear counter or raise flag");

  chk_no_p_flag: assert property (
    (mode == STML_MODE_CMP && clear_source_select && !match_p_flag)
    |=> !match_p_flag)
    else $error("P flag raised with clear source on A");

  chk_pin_a_only: assert property (
    (mode == STML_MODE_CMP && !a_hit && !en_rise && !reg_wr)[*3]
    |-> $stable(timer_pin_out))
    else $error("compare pin changed without A match");

  chk_timer_idle: assert property (
    (mode == STML_MODE_TMR)[*2] |-> !timer_pin_oe)
    else $error("pin driven in timer mode");

  chk_pwm_full: assert property (
    (mode == STML_MODE_PWM && pin_action == `STML_IO_10 && !period_duty_swap
     && ({1'b0, compare_a_value_q} >= p_span) && !reg_wr)[*2]
    |-> (timer_pin_out == (output_initial_level ^ output_invert)))
    else $error("full duty PWM left active level");

  chk_trig_start: assert property (
    (single && trig_edge && !counter_enable_q)
    |=> counter_enable_q && (cnt_q == `STML_CNT_ZERO))
    else $error("trigger edge did not start pulse");

  chk_pulse_end: assert property (
    (single && a_hit) |=> !counter_enable_q && match_a_flag)
    else $error("A match did not end pulse");

  chk_capture_latch: assert property (
    cap_fire |=> (compare_a_value_q == $past(cnt_q)) && match_a_flag)
    else $error("capture did not latch counter");

  chk_capture_off: assert property (
    (mode == STML_MODE_CAP && pin_action == `STML_IO_11 && !wr_a)
    |=> $stable(compare_a_value_q))
    else $error("capture happened while disabled");

  chk_cap_p_clear: assert property (
    (mode == STML_MODE_CAP && p_hit && !en_rise)
    |=> (cnt_q == `STML_CNT_ZERO) && match_p_flag)
    else $error("capture P match did not clear counter");

  chk_a_match_clear: assert property (
    (mode == STML_MODE_CMP && clear_source_select && a_hit && !en_rise)
    |=> (cnt_q == `STML_CNT_ZERO) && match_a_flag)
    else $error("A match did not clear counter with clear source on A");

  chk_count_step: assert property (
    (tick && !en_rise && !a_hit && !p_hit)
    |=> (cnt_q == $past(cnt_q) + `STML_CNT_ONE))
    else $error("counter did not advance by one on tick");

  chk_pwm_swap_clear: assert property (
    (mode == STML_MODE_PWM && !single && period_duty_swap && a_hit && !en_rise)
    |=> (cnt_q == `STML_CNT_ZERO))
    else $error("A match did not end PWM period with swap set");

  chk_cap_no_drive: assert property (
    (mode == STML_MODE_CAP)[*2]
    |-> !timer_pin_oe)
    else $error("pin driven in capture mode");

  chk_pwm_drive: assert property (
    (mode == STML_MODE_PWM)[*2]
    |-> timer_pin_oe)
    else $error("pin not driven in PWM mode");

  chk_pwm_inactive: assert property (
    (mode == STML_MODE_PWM && pin_action == `STML_IO_00 && !wr_c1)[*2]
    |-> (timer_pin_out == (!output_initial_level ^ output_invert)))
    else $error("PWM pin not at inactive level");

  chk_cmp_drive_high: assert property (
    (mode == STML_MODE_CMP && pin_action == `STML_IO_10 && a_hit && !en_rise)
    |=> (timer_pin_out == !$past(output_invert)))
    else $error("A match did not drive pin high");

endmodule

//--- sim/stml_pin_model.sv
/*
 Far side of the timer pins: capture source level and single-pulse trigger.
 Assumes its tasks are called right after a rising core_clk edge.
*/
`timescale 1ns/1ps
module stml_pin_model (
  input  wire logic core_clk,
  input  wire logic timer_pin_out,
  input  wire logic timer_pin_oe,
  output logic      timer_pin_in,
  output logic      external_trigger_pin
);
  logic lvl_q = 1'b0;

  // Shared pin: timer level while it drives, else the far side's level
  assign timer_pin_in = timer_pin_oe ? timer_pin_out : lvl_q;

  initial external_trigger_pin = 1'b0;

  task automatic drive(input logic v);
    lvl_q <= v;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic trigger();
    external_trigger_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    external_trigger_pin <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule

//--- sim/tb_stml_timer.sv
/*
 Bench for stml_timer: register tasks, then mode scenarios with fixed ticks.
 Assumes stml_pin_model as the far side of the timer pins.
*/
`timescale 1ns/1ps
`include "stml_consts.svh"
module tb_stml_timer
  import stml_pkg::*;
;
  localparam logic [2:0] C0  = `STML_ADDR_CTRL0;
  localparam logic [2:0] C1  = `STML_ADDR_CTRL1;
  localparam logic [2:0] CNT = `STML_ADDR_COUNT;
  localparam logic [2:0] CA  = `STML_ADDR_CMPA;
  localparam logic [2:0] FL  = `STML_ADDR_FLAGS;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        count_tick = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] rv;
  logic        timer_pin_out;
  logic        timer_pin_oe;
  logic        timer_pin_in;
  logic        external_trigger_pin;
  logic        match_a_flag;
  logic        match_p_flag;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  wire  [15:0] fl_v = {14'h0, match_p_flag, match_a_flag};
  wire  [15:0] pin_v = {15'h0, timer_pin_out};
  wire  [15:0] oe_v = {15'h0, timer_pin_oe};

  always #4 core_clk = ~core_clk;

  stml_timer i_stml_timer (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_tick(count_tick),
    .external_trigger_pin(external_trigger_pin), .timer_pin_in(timer_pin_in),
    .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag)
  );

  stml_pin_model i_stml_pin_model (
    .core_clk(core_clk), .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
    .timer_pin_in(timer_pin_in), .external_trigger_pin(external_trigger_pin)
  );

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [2:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    @(posedge core_clk);
  endtask

  // Exactly n timer clocks, then the counter stands still
  task automatic run(input int n);
    count_tick <= 1'b1;
    repeat (n) @(posedge core_clk);
    count_tick <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic [7:0] cfg(stml_mode_t m, logic [1:0] io, logic oc, logic pol,
                                     logic dpx, logic cclr);
    return {m, io, oc, pol, dpx, cclr};
  endfunction

  task automatic start(input logic [7:0] c, input logic [2:0] p);
    wr(C0, 16'h0000);
    wr(C1, {8'h00, c});
    wr(FL, 16'h0003);
    wr(C0, {12'h000, 1'b1, p});
  endtask

  initial begin
    logic [1:0] io;
    logic       oc;
    logic       pol;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a < 6; a++) begin
      rd(a[2:0]);
      chk(rv, 16'h0000);
    end
    wr(CA, 16'h0005);
    for (int k = 0; k < 8; k++) begin
      start(cfg(STML_MODE_CMP, k[1:0], k[2], 1'b0, 1'b0, 1'b0), 3'h1);
      chk(pin_v, 16'(k[2]));
      run(5);
      chk(pin_v, 16'((k[1:0] == 2'h0) ? k[2] : (k[1:0] == 2'h3) ? !k[2] : k[1]));
    end
    run(122);
    rd(CNT);
    chk(rv, 16'h007F);
    chk(fl_v, 16'h0001);
    run(1);
    chk(fl_v, 16'h0003);
    chk(pin_v, 16'h0000);
    rd(CNT);
    chk(rv, 16'h0000);
    run(5);
    chk(pin_v, 16'h0001);
    start(cfg(STML_MODE_CMP, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 3'h0);
    run(1023);
    rd(CNT);
    chk(rv, 16'h03FF);
    run(1);
    chk(fl_v, 16'h0003);
    run(9);
    wr(C0, 16'h0000);
    run(4);
    rd(CNT);
    chk(rv, 16'h0009);
    wr(C0, 16'h0008);
    rd(CNT);
    chk(rv, 16'h0000);
    wr(CA, 16'h00C8);
    start(cfg(STML_MODE_CMP, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1), 3'h1);
    run(199);
    chk(fl_v, 16'h0000);
    run(1);
    chk(fl_v, 16'h0001);
    rd(CNT);
    chk(rv, 16'h0000);
    wr(CA, 16'h0005);
    start(cfg(STML_MODE_TMR, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0), 3'h1);
    run(128);
    chk(fl_v, 16'h0003);
    chk(oe_v, 16'h0000);
    wr(CA, 16'h0020);
    for (int k = 0; k < 12; k++) begin
      io = 2'(k % 3);
      oc = 1'((k / 3) % 2);
      pol = 1'(k / 6);
      start(cfg(STML_MODE_PWM, io, oc, pol, 1'b0, 1'b1), 3'h1);
      chk(pin_v, 16'(io == 2'h0 ? !(oc ^ pol) : oc ^ pol));
      run(32);
      chk(pin_v, 16'(io == 2'h1 ? oc ^ pol : !(oc ^ pol)));
      run(96);
      chk(fl_v, 16'h0003);
    end
    wr(CA, 16'h00C8);
    start(cfg(STML_MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0), 3'h1);
    run(127);
    chk(pin_v, 16'h0001);
    run(1);
    chk(pin_v, 16'h0001);
    chk(fl_v, 16'h0002);
    wr(CA, 16'h012C);
    start(cfg(STML_MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0), 3'h1);
    run(128);
    chk(pin_v, 16'h0000);
    run(172);
    rd(CNT);
    chk(rv, 16'h0000);
    chk(pin_v, 16'h0001);
    wr(CA, 16'h000A);
    wr(C0, 16'h0000);
    wr(C1, {8'h00, cfg(STML_MODE_PWM, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0)});
    wr(FL, 16'h0003);
    i_stml_pin_model.trigger();
    chk(pin_v, 16'h0001);
    rd(C0);
    chk(rv, 16'h0008);
    run(10);
    chk(pin_v, 16'h0000);
    chk(fl_v, 16'h0001);
    rd(C0);
    chk(rv, 16'h0000);
    run(5);
    rd(CNT);
    chk(rv, 16'h000A);
    wr(C0, 16'h0008);
    chk(pin_v, 16'h0001);
    rd(CNT);
    chk(rv, 16'h0000);
    wr(C0, 16'h0000);
    chk(pin_v, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(CA, 16'h03FF);
      start(cfg(STML_MODE_CAP, k[1:0], 1'b1, 1'b1, 1'b0, 1'b1), 3'h1);
      chk(oe_v, 16'h0000);
      run(20);
      i_stml_pin_model.drive(1'b1);
      rd(CA);
      chk(rv, (k == 0 || k == 2) ? 16'h0014 : 16'h03FF);
      run(10);
      i_stml_pin_model.drive(1'b0);
      rd(CA);
      chk(rv, (k == 1 || k == 2) ? 16'h001E : (k == 0) ? 16'h0014 : 16'h03FF);
      chk(fl_v, (k == 3) ? 16'h0000 : 16'h0001);
    end
    run(98);
    chk(fl_v, 16'h0002);
    rd(CNT);
    chk(rv, 16'h0000);
    complete_run();
  end
endmodule
